// ===== inc/dpsr_pkg.sv
// Shared constants and bundles for the dual-port synchronous RAM port logic
package dpsr_pkg;

	// Array word and lane geometry
	localparam int DATA_W = 16;
	localparam int LANE_W = 8;
	localparam int LANES = DATA_W / LANE_W;
	localparam int PORTS = 2;

	// Address pins; the smaller variant leaves the top bit unused
	localparam int ADDR_PIN_W = 15;
	localparam int ADDR_W_LARGE = 15;
	localparam int ADDR_W_SMALL = 14;

	// Pin synchroniser depth against the system clock
	localparam int SYNC_STAGES = 3;

	// System clock rate
	localparam longint CLOCK_HZ = 25_000_000;

	// Reset values of the port state
	localparam logic [ADDR_PIN_W-1:0] ADDR_RST = 15'h0000;
	localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
	localparam logic [LANES-1:0] LANE_OFF_N = 2'h3;

	// Synchronous inputs of one port, sampled on its own clock
	typedef struct packed {
		logic select_active_low;     // Low half of the dual select
		logic select_active_high;    // High half of the dual select
		logic upper_lane_select_n;   // Bits 15..8 lane select
		logic lower_lane_select_n;   // Bits 7..0 lane select
		logic read_not_write;        // High reads, low writes
		logic address_load_strobe_n; // Load external address
		logic burst_advance_n;       // Advance internal address
		logic burst_zero_n;          // Force internal address to zero
		logic [ADDR_PIN_W-1:0] addr; // External address
		logic [DATA_W-1:0] wdata;    // Write data
	} dpsr_pins_s;

	// Data lane drive of one port
	typedef struct packed {
		logic [DATA_W-1:0] dq_out;   // Read data towards the pins
		logic [LANES-1:0] dq_oe_n;   // Per lane enable, low drives
	} dpsr_drive_s;

endpackage

// ===== verif/dpsr_master.sv
// Synchronous bus master model for one port of the RAM
module dpsr_master #(parameter logic PIPE = 1'b0) (
	input wire logic clock, // System clock
	output logic pclk, // Port clock
	output dpsr_pkg::dpsr_pins_s pins, // Port inputs
	output logic oe_n, // Output enable
	output logic mode // Output mode
);
	timeunit 1ns;
	timeprecision 1ns;
	// Mode is a fixed strap, never toggled in a run
	assign mode = PIPE;
	// Idle port clock low, counter on hold
	initial begin
		pclk = 1'b0;
		pins = {8'h4f, 31'h0};
		oe_n = 1'b0;
	end
	// One access, held round the port clock rise
	task automatic op(input logic [7:0] c, input logic [14:0] a,
		input logic [15:0] d);
		@(negedge clock);
		pins <= {c, a, c[3] ? ~pins.wdata : d};
		repeat (4) @(negedge clock);
		pclk <= 1'b1;
		repeat (4) @(negedge clock);
		pclk <= 1'b0;
		repeat (4) @(negedge clock);
	endtask
endmodule // dpsr_master

// ===== verif/dpsr_port_props.sv
// Port timing and lane checks for the RAM port logic
module dpsr_port_props #(parameter int ADDR_W = dpsr_pkg::ADDR_W_LARGE) (
	input wire logic clock, arst_n, left_port_clock, right_port_clock,
	input wire dpsr_pkg::dpsr_pins_s left_pins, right_pins,
	input wire logic left_output_enable_n, right_output_enable_n,
	input wire logic left_output_mode_select, right_output_mode_select,
	input wire dpsr_pkg::dpsr_drive_s left_drive, right_drive,
	input wire logic left_standby, right_standby
);
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	// Flow-through read and write requests on the left port
	wire logic lrd = left_pins[38:31] == 8'h4b && !left_output_mode_select;
	wire logic lwr = left_pins[38:31] == 8'h43 && !left_output_mode_select;
	chk_reset_quiet: assert property ($rose(arst_n) |-> left_standby &&
		left_drive.dq_oe_n == 2'h3) else $error("Outputs live at reset");
	chk_oe_float: assert property (left_output_enable_n [*6] |->
		left_drive.dq_oe_n == 2'h3) else $error("Lanes driven, oe high");
	chk_sby_float: assert property (left_standby |->
		left_drive.dq_oe_n == 2'h3) else $error("Standby port drives");
	chk_left_quiet: assert property (!left_port_clock [*8] |->
		$stable(left_drive.dq_out) && $stable(left_standby))
		else $error("Left moved without clock");
	chk_right_quiet: assert property (!right_port_clock [*8] |->
		$stable(right_drive.dq_out) && $stable(right_standby))
		else $error("Right moved without clock");
	chk_ft_read: assert property ($rose(left_port_clock) && lrd &&
		!left_output_enable_n |-> ##[4:7] left_drive.dq_oe_n == 2'h0)
		else $error("Read lanes not driven");
	chk_ft_write: assert property ($rose(left_port_clock) && lwr |->
		##[4:7] left_drive.dq_oe_n == 2'h3) else $error("Write drives");
	chk_ft_desel: assert property ($rose(left_port_clock) &&
		left_pins.select_active_low && !left_output_mode_select |->
		##[4:7] left_standby) else $error("Deselect late");
	cov_left_read: cover property (left_drive.dq_oe_n == 2'h0);
	cov_right_read: cover property (right_drive.dq_oe_n == 2'h0);
	cov_desel: cover property ($rose(left_standby));
endmodule // dpsr_port_props
bind dpsr_port_core dpsr_port_props #(.ADDR_W(ADDR_W)) chk_u (.*);

// ===== verif/tb.sv
// Self-checking bench for the dual-port RAM port logic
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
	$display("Error at %0t: %h vs %h", $time, a, b); end end
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock, arst_n, lpc, rpc, loe_n, roe_n, lmode, rmode, lsby, rsby;
	dpsr_pkg::dpsr_pins_s lpins, rpins;
	dpsr_pkg::dpsr_drive_s ld, rd;
	int n_fail = 0;
	int checks = 0;
	dpsr_port_core dut_u (.clock(clock), .arst_n(arst_n),
		.left_port_clock(lpc), .right_port_clock(rpc),
		.left_pins(lpins), .right_pins(rpins),
		.left_output_enable_n(loe_n), .right_output_enable_n(roe_n),
		.left_output_mode_select(lmode), .right_output_mode_select(rmode),
		.left_drive(ld), .right_drive(rd),
		.left_standby(lsby), .right_standby(rsby));
	dpsr_master #(.PIPE(1'b0)) lm (.clock(clock), .pclk(lpc),
		.pins(lpins), .oe_n(loe_n), .mode(lmode));
	dpsr_master #(.PIPE(1'b1)) rm (.clock(clock), .pclk(rpc),
		.pins(rpins), .oe_n(roe_n), .mode(rmode));
	// 25 MHz system clock
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	task automatic end_sim;
		$display("Checks %0d, mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Lane writes, top address bit, partial read
	task automatic t_rw;
		lm.op(8'h43, 15'h0123, 16'ha5c3);
		lm.op(8'h53, 15'h0123, 16'h1e00);
		lm.op(8'h4b, 15'h0123, 16'h0);
		`CHK(ld.dq_out, 16'h1ec3)
		lm.op(8'h63, 15'h0123, 16'h9977);
		lm.op(8'h73, 15'h0123, 16'hffff);
		lm.op(8'h43, 15'h4123, 16'h3c3c);
		lm.op(8'h4b, 15'h0123, 16'h0);
		`CHK(ld.dq_out, 16'h1e77)
		`CHK(ld.dq_oe_n, 2'h0)
		lm.op(8'h5b, 15'h0123, 16'h0);
		`CHK(ld.dq_oe_n, 2'h1)
		$display("t_rw done");
	endtask
	// Burst counter zero, advance, hold and load
	task automatic t_counter;
		lm.op(8'h42, 15'h7fff, 16'h1111);
		lm.op(8'h45, 15'h7fff, 16'h2222);
		lm.op(8'h4f, 15'h0000, 16'h0);
		`CHK(ld.dq_out, 16'h2222)
		lm.op(8'h4b, 15'h0000, 16'h0);
		`CHK(ld.dq_out, 16'h1111)
		lm.op(8'h4d, 15'h0000, 16'h0);
		`CHK(ld.dq_out, 16'h2222)
		$display("t_counter done");
	endtask
	// Deselect by low select high blocks a write; by high select low floats a read
	task automatic t_desel;
		lm.op(8'hc3, 15'h0000, 16'hdead);
		`CHK(lsby, 1'b1)
		lm.op(8'h0b, 15'h0000, 16'h0);
		`CHK(ld.dq_oe_n, 2'h3)
		lm.op(8'h4b, 15'h0000, 16'h0);
		`CHK(ld.dq_out, 16'h1111)
		`CHK(lsby, 1'b0)
		$display("t_desel done");
	endtask
	// Output enable floats lanes while a read stands
	task automatic t_oe;
		lm.oe_n <= 1'b1;
		repeat (8) @(negedge clock);
		`CHK(ld.dq_oe_n, 2'h3)
		lm.oe_n <= 1'b0;
		repeat (8) @(negedge clock);
		`CHK(ld.dq_oe_n, 2'h0)
		$display("t_oe done");
	endtask
	// Pipelined right port: extra cycle, double select stage
	task automatic t_pipe;
		rm.op(8'h43, 15'h0002, 16'h5a5a);
		rm.op(8'h4b, 15'h0123, 16'h0);
		`CHK(rd.dq_oe_n, 2'h3)
		rm.op(8'h4b, 15'h0002, 16'h0);
		`CHK(rd.dq_out, 16'h1e77)
		rm.op(8'hcb, 15'h0000, 16'h0);
		`CHK(rd.dq_out, 16'h5a5a)
		`CHK(rsby, 1'b0)
		rm.op(8'h4f, 15'h0000, 16'h0);
		`CHK(rsby, 1'b1)
		$display("t_pipe done");
	endtask
	// Watchdog well past the expected run length
	initial begin
		#400000;
		n_fail++;
		end_sim;
	end
	// Reset, then the scenarios in order
	initial begin
		arst_n = 1'b0;
		repeat (20) @(posedge clock);
		@(negedge clock);
		arst_n <= 1'b1;
		t_rw;
		t_counter;
		t_desel;
		t_oe;
		t_pipe;
		end_sim;
	end
endmodule // tb

// ===== verilog/dpsr_port_core.sv
// Two-port synchronous RAM with burst counters and selectable output mode
//
// Contract
// R1: Shared 16-bit array; both ports reach any word, even the same one.
// R2: Each port registers control, address and data on its own clock rise.
// R3: Left inputs sampled only by left clock, right only by right clock.
// R4: Port selected only with low select low and high select high.
// R5: Selects take one stage in flow-through, two stages in pipelined mode.
// R6: Lane selects pass one register stage in either output mode.
// R7: Write stores each lane whose select is low; none when both high.
// R8: Read drives lanes whose select is low when output enable is low.
// R9: Output enable high floats both lanes whatever else is set.
// R10: A write completes within one port clock cycle.
// R11: Strobe low with zero high loads the external address.
// R12: Strobe high, advance low, zero high increments the internal address.
// R13: Strobe, advance and zero all high keep the internal address.
// R14: Zero low clears the internal address regardless of other controls.
// R15: Each port picks flow-through or pipelined output by its mode input.
// R16: Pipelined read data arrives one port cycle after flow-through.
// R17: Address is 15 bits; the small variant ignores the top bit.
// R18: Mode high means pipelined, low means flow-through, per port.
// R19: Master keeps the mode input static during operation.
// R20: Deselect or high lane select floats outputs after the next rise; in pipelined mode a deselect floats them after the second rise.
// R21: Masters avoid writing one address from both ports at once.
module dpsr_port_core #(
	parameter int ADDR_W = dpsr_pkg::ADDR_W_LARGE
) (
	input wire logic clock,                          // 25 MHz system clock
	input wire logic arst_n,                         // Async reset, low
	input wire logic left_port_clock,                // Left port clock pin
	input wire logic right_port_clock,               // Right port clock pin
	input wire dpsr_pkg::dpsr_pins_s left_pins,      // Left sync inputs
	input wire dpsr_pkg::dpsr_pins_s right_pins,     // Right sync inputs
	input wire logic left_output_enable_n,           // Left lane enable
	input wire logic right_output_enable_n,          // Right lane enable
	input wire logic left_output_mode_select,        // Left: high pipelined
	input wire logic right_output_mode_select,       // Right: high pipelined
	output dpsr_pkg::dpsr_drive_s left_drive,        // Left data and enables
	output dpsr_pkg::dpsr_drive_s right_drive,       // Right data and enables
	output logic left_standby,                       // Left deselected
	output logic right_standby                       // Right deselected
);

	localparam int DEPTH = 1 << ADDR_W;
	localparam int DW = dpsr_pkg::DATA_W;
	localparam int LN = dpsr_pkg::LANES;
	localparam int LW = dpsr_pkg::LANE_W;
	localparam int NP = dpsr_pkg::PORTS;
	localparam int SS = dpsr_pkg::SYNC_STAGES;

	// Shared storage cells
	logic [DW-1:0] mem [DEPTH]; // R1

	// Port-indexed views of the pins
	logic [NP-1:0] port_clk;
	logic [NP-1:0] port_oe_n;
	logic [NP-1:0] port_mode;
	dpsr_pkg::dpsr_pins_s port_pins [NP];

	// Write requests handed to the array
	logic [NP-1:0] wr_en;
	logic [LN-1:0] wr_lane [NP];
	logic [ADDR_W-1:0] wr_addr [NP];
	logic [DW-1:0] wr_data [NP];

	assign port_clk = {right_port_clock, left_port_clock};
	assign port_oe_n = {right_output_enable_n, left_output_enable_n};
	assign port_mode = {right_output_mode_select, left_output_mode_select};
	assign port_pins[0] = left_pins;
	assign port_pins[1] = right_pins;

	// Array writes; each enabled lane stored in the cycle of the edge
	always_ff @(posedge clock) begin
		for (int p = 0; p < NP; p++) begin
			for (int l = 0; l < LN; l++) begin
				if (wr_en[p] && wr_lane[p][l]) begin // R7 R10
					mem[wr_addr[p]][l*LW +: LW] <= wr_data[p][l*LW +: LW];
				end
			end
		end
	end

	for (genvar gp = 0; gp < NP; gp++) begin : g_port
		// Pin synchronisers
		logic [SS-1:0] clk_sync_reg;
		logic [SS-1:0] oe_sync_reg;
		logic [SS-1:0] mode_sync_reg;
		dpsr_pkg::dpsr_pins_s pin_s1_reg;
		dpsr_pkg::dpsr_pins_s pin_s2_reg;
		dpsr_pkg::dpsr_pins_s pin_s3_reg;
		dpsr_pkg::dpsr_pins_s pin_lvl_reg;
		logic clk_lvl_reg;
		logic oe_lvl_reg;
		logic mode_lvl_reg;
		logic port_edge;

		// Access state of the port
		logic [ADDR_W-1:0] addr_reg;
		logic [ADDR_W-1:0] addr_next;
		logic sel1_reg;
		logic sel2_reg;
		logic rd1_reg;
		logic rd2_reg;
		logic [LN-1:0] lane1_reg;
		logic [DW-1:0] rdata1_reg;
		logic [DW-1:0] rdata2_reg;
		logic sel_eff;
		logic rd_eff;
		logic [DW-1:0] data_eff;
		logic [LN-1:0] lane_drive;
		dpsr_pkg::dpsr_pins_s pin;
		logic selected;

		// Outputs of this port, straight from flip-flops
		logic [DW-1:0] dq_reg;
		logic [LN-1:0] lane_off_n_reg;
		logic standby_reg;
		dpsr_pkg::dpsr_drive_s drive;

		// Three flops on the port clock pin
		always_ff @(posedge clock or negedge arst_n) begin
			if (!arst_n) begin
				clk_sync_reg <= '0;
			end else begin
				clk_sync_reg <= {clk_sync_reg[SS-2:0], port_clk[gp]};
			end
		end

		// Three flops on the output enable pin, idle high
		always_ff @(posedge clock or negedge arst_n) begin
			if (!arst_n) begin
				oe_sync_reg <= '1;
			end else begin
				oe_sync_reg <= {oe_sync_reg[SS-2:0], port_oe_n[gp]};
			end
		end

		// Three flops on the static output mode pin
		always_ff @(posedge clock or negedge arst_n) begin
			if (!arst_n) begin
				mode_sync_reg <= '0;
			end else begin
				mode_sync_reg <= {mode_sync_reg[SS-2:0], port_mode[gp]};
			end
		end

		// Three copies of the synchronous port inputs
		always_ff @(posedge clock or negedge arst_n) begin
			if (!arst_n) begin
				pin_s1_reg <= '0;
				pin_s2_reg <= '0;
				pin_s3_reg <= '0;
			end else begin
				pin_s1_reg <= port_pins[gp];
				pin_s2_reg <= pin_s1_reg;
				pin_s3_reg <= pin_s2_reg;
			end
		end

		// Each input bit moves only where stages two and three agree
		always_ff @(posedge clock or negedge arst_n) begin
			if (!arst_n) begin
				pin_lvl_reg <= '0;
			end else begin
				pin_lvl_reg <= (pin_s2_reg & pin_s3_reg) |
					(pin_lvl_reg & (pin_s2_reg | pin_s3_reg)); // R2
			end
		end

		// Agreed port clock level
		always_ff @(posedge clock or negedge arst_n) begin
			if (!arst_n) begin
				clk_lvl_reg <= 1'b0;
			end else if (clk_sync_reg[1] == clk_sync_reg[2]) begin
				clk_lvl_reg <= clk_sync_reg[2];
			end
		end

		// Agreed output enable level, slow against the port clock
		always_ff @(posedge clock or negedge arst_n) begin
			if (!arst_n) begin
				oe_lvl_reg <= 1'b1;
			end else if (oe_sync_reg[1] == oe_sync_reg[2]) begin
				oe_lvl_reg <= oe_sync_reg[2];
			end
		end

		// Agreed output mode level
		always_ff @(posedge clock or negedge arst_n) begin
			if (!arst_n) begin
				mode_lvl_reg <= 1'b0;
			end else if (mode_sync_reg[1] == mode_sync_reg[2]) begin
				mode_lvl_reg <= mode_sync_reg[2]; // R19
			end
		end

		// Rising edge of this port's own clock only
		assign port_edge = clk_sync_reg[1] && clk_sync_reg[2] &&
			!clk_lvl_reg; // R2 R3

		// Agreed inputs and the dual select decode
		assign pin = pin_lvl_reg;
		assign selected = !pin.select_active_low &&
			pin.select_active_high; // R4

		// Burst counter: zero beats load, load beats advance, else hold
		always_comb begin
			addr_next = addr_reg;
			if (!pin.burst_zero_n) begin
				addr_next = '0; // R14
			end else if (!pin.address_load_strobe_n) begin
				addr_next = pin.addr[ADDR_W-1:0]; // R11 R17
			end else if (!pin.burst_advance_n) begin
				addr_next = addr_reg + ADDR_W'(1); // R12
			end else begin
				addr_next = addr_reg; // R13
			end
		end

		// Internal address register, updated regardless of selects
		always_ff @(posedge clock or negedge arst_n) begin
			if (!arst_n) begin
				addr_reg <= dpsr_pkg::ADDR_RST[ADDR_W-1:0];
			end else if (port_edge) begin
				addr_reg <= addr_next; // R11 R12 R13 R14
			end
		end

		// Write request for the array in the edge cycle
		assign wr_en[gp] = port_edge && selected &&
			!pin.read_not_write; // R7 R10
		assign wr_lane[gp] = ~{pin.upper_lane_select_n,
			pin.lower_lane_select_n}; // R7

		// Address and word of the write, the same as a read would use
		assign wr_addr[gp] = addr_next;
		assign wr_data[gp] = pin.wdata;

		// Select after one register stage
		always_ff @(posedge clock or negedge arst_n) begin
			if (!arst_n) begin
				sel1_reg <= 1'b0;
			end else if (port_edge) begin
				sel1_reg <= selected; // R5
			end
		end

		// Direction of the latest access
		always_ff @(posedge clock or negedge arst_n) begin
			if (!arst_n) begin
				rd1_reg <= 1'b0;
			end else if (port_edge) begin
				rd1_reg <= pin.read_not_write; // R8
			end
		end

		// Lane selects, a single stage in either mode
		always_ff @(posedge clock or negedge arst_n) begin
			if (!arst_n) begin
				lane1_reg <= '0;
			end else if (port_edge) begin
				lane1_reg <= ~{pin.upper_lane_select_n,
					pin.lower_lane_select_n}; // R6
			end
		end

		// Word at the address used by this access
		always_ff @(posedge clock or negedge arst_n) begin
			if (!arst_n) begin
				rdata1_reg <= dpsr_pkg::DATA_RST;
			end else if (port_edge) begin
				rdata1_reg <= mem[addr_next]; // R1
			end
		end

		// Second select stage for pipelined mode
		always_ff @(posedge clock or negedge arst_n) begin
			if (!arst_n) begin
				sel2_reg <= 1'b0;
			end else if (port_edge) begin
				sel2_reg <= sel1_reg; // R5
			end
		end

		// Second direction stage, kept in step with the select
		always_ff @(posedge clock or negedge arst_n) begin
			if (!arst_n) begin
				rd2_reg <= 1'b0;
			end else if (port_edge) begin
				rd2_reg <= rd1_reg;
			end
		end

		// Extra output register of pipelined mode
		always_ff @(posedge clock or negedge arst_n) begin
			if (!arst_n) begin
				rdata2_reg <= dpsr_pkg::DATA_RST;
			end else if (port_edge) begin
				rdata2_reg <= rdata1_reg; // R16
			end
		end

		// Mode picks one or two stages for selects and data
		assign sel_eff = mode_lvl_reg ? sel2_reg : sel1_reg; // R5 R18
		assign rd_eff = mode_lvl_reg ? rd2_reg : rd1_reg;
		assign data_eff = mode_lvl_reg ? rdata2_reg : rdata1_reg; // R15 R16

		// Per lane drive decision
		for (genvar gl = 0; gl < LN; gl++) begin : g_lane
			assign lane_drive[gl] = !oe_lvl_reg && sel_eff && rd_eff &&
				lane1_reg[gl]; // R8 R9 R20
		end

		// Registered read data towards the pins
		always_ff @(posedge clock or negedge arst_n) begin
			if (!arst_n) begin
				dq_reg <= dpsr_pkg::DATA_RST;
			end else begin
				dq_reg <= data_eff;
			end
		end

		// Registered lane enables, low drives
		always_ff @(posedge clock or negedge arst_n) begin
			if (!arst_n) begin
				lane_off_n_reg <= dpsr_pkg::LANE_OFF_N;
			end else begin
				lane_off_n_reg <= ~lane_drive; // R8 R9
			end
		end

		// Standby follows the effective select
		always_ff @(posedge clock or negedge arst_n) begin
			if (!arst_n) begin
				standby_reg <= 1'b1;
			end else begin
				standby_reg <= !sel_eff; // R4
			end
		end

		// Bundle of the registered data and lane enables
		assign drive = '{dq_out: dq_reg, dq_oe_n: lane_off_n_reg};
	end

	// Top-level outputs
	assign left_drive = g_port[0].drive;
	assign right_drive = g_port[1].drive;
	assign left_standby = g_port[0].standby_reg;
	assign right_standby = g_port[1].standby_reg;

endmodule // dpsr_port_core
